/* File: include/rtc_guard_pkg.sv */
// constants for the timekeeping register file and power guard
package rtc_guard_pkg;
  // register offsets (four-bit register address)
  localparam logic [3:0] OFS_STATUS_FLAGS   = 4'h0;
  localparam logic [3:0] OFS_CENTURY        = 4'h1;
  localparam logic [3:0] OFS_ALARM_SEC      = 4'h2;
  localparam logic [3:0] OFS_ALARM_MIN      = 4'h3;
  localparam logic [3:0] OFS_ALARM_HOUR     = 4'h4;
  localparam logic [3:0] OFS_ALARM_DAY      = 4'h5;
  localparam logic [3:0] OFS_ALARM_MONTH    = 4'h6;
  localparam logic [3:0] OFS_TIMEOUT_CFG    = 4'h7;
  localparam logic [3:0] OFS_CONTROL        = 4'h8;
  localparam logic [3:0] OFS_SECONDS        = 4'h9;
  localparam logic [3:0] OFS_MINUTES        = 4'ha;
  localparam logic [3:0] OFS_HOURS          = 4'hb;
  localparam logic [3:0] OFS_WEEKDAY        = 4'hc;
  localparam logic [3:0] OFS_DAY_OF_MONTH   = 4'hd;
  localparam logic [3:0] OFS_MONTH          = 4'he;
  localparam logic [3:0] OFS_YEAR           = 4'hf;
  // field positions
  localparam int BIT_SET_TIME      = 7;  // control register
  localparam int BIT_FREEZE        = 6;  // control register
  localparam int BIT_OSC_HALT      = 7;  // seconds register
  localparam int BIT_FREQ_TEST     = 6;  // weekday register
  localparam int BIT_WD_EXPIRED    = 7;  // flags
  localparam int BIT_ALARM_MATCH   = 6;  // flags
  localparam int BIT_BATT_LOW      = 4;  // flags
  localparam int BIT_WD_ROUTE      = 7;  // timeout config
  localparam int BIT_ALARM_IRQ_EN  = 7;  // alarm month
  localparam int BIT_ALARM_BACKUP  = 5;  // alarm month
  // reset values
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] RST_CONTROL   = 8'h40; // freeze set, set-time clear
  localparam logic [7:0] RST_DAY_MONTH = 8'h01;
  // timing
  localparam longint CLK_HZ          = 250000000;
  localparam longint RECOVERY_MS     = 200;
  localparam longint RECOVERY_CYCLES = (RECOVERY_MS * CLK_HZ) / 1000; // longest time: round down
  localparam longint SECOND_CYCLES   = CLK_HZ;
endpackage

/* File: logic/rtc_register_file_power_guard.sv */
// timekeeping register file with power-fail write protection
// Notes on behaviour
// - while supply is under deselect threshold, all host register accesses are ignored
// - system reset output goes active at deselect and stays until the recovery period after supply return ends
// - both external memory selects forced high while supply out of tolerance
// - below switchover threshold all outputs go high impedance, registers retained
// - after supply returns, memory selects stay inhibited for the 200 ms recovery period
// - system reset stays active through the recovery period, released when it ends
// - sixteen byte registers selected by a four-bit address
// - visible time copies refreshed together from incremented counters each second
// - time and alarm registers are BCD, control/watchdog/flags are binary
// - freeze bit D6 of control register halts transfers to visible copies
// - frozen copies show the time current when freeze was set
// - an update in progress completes before a freeze takes effect
// - clearing freeze makes the next update one second later
// - set-time bit D7 of control register halts visible updates for loading
// - clearing set-time loads counters from Fh-9h and 1h, next update one second later
// - power-up after failure sets freeze and clears set-time
// - oscillator halt bit stops counting; clearing resumes within one second
// - halt and frequency test bits are written without needing set-time
// - flags register shows watchdog, alarm and battery-low flags, read only
// - timeout config holds route select, five-bit multiplier, two-bit resolution
// - alarm month holds irq and backup enables; repeat bits sit in top bits of 5h-2h
// - read happens with select and output enable low and write strobe high, address picks register
// - write spans later falling edge of select/strobe to earlier rising edge
module rtc_register_file_power_guard #(
  parameter longint RECOVERY_COUNT = rtc_guard_pkg::RECOVERY_CYCLES,
  parameter longint SECOND_COUNT   = rtc_guard_pkg::SECOND_CYCLES
) (
  input  wire logic       clk_sys,                // 250 MHz system clock
  input  wire logic       rst,                    // async reset, active high
  input  wire logic       reg_sel_n,              // register select, active low
  input  wire logic       wr_strobe_n,            // write strobe, active low
  input  wire logic       rd_enable_n,            // output enable, active low
  input  wire logic [3:0] reg_addr,               // register address
  input  wire logic [7:0] data_in,                // data bus input
  output logic      [7:0] data_out,               // data bus output
  output logic            data_oe,                // data bus drive enable
  input  wire logic       mem_sel_in_n,           // host external memory select
  output logic            mem_sel0_out_n,         // external memory select 0
  output logic            mem_sel1_out_n,         // external memory select 1
  output logic            mem_sel_oe,             // memory select drive enable
  output logic            sys_rst_out,            // reset pin pulls low while high
  output logic            sys_rst_oe,             // reset open-drain enable
  input  wire logic       deselect_threshold,     // supply under deselect threshold
  input  wire logic       switchover_threshold,   // supply under switchover threshold
  input  wire logic       wd_expired_in,          // watchdog expiry event
  input  wire logic       alarm_match_in,         // alarm match event
  input  wire logic       batt_low_in,            // battery low level
  input  wire logic       bank_sel                // bank chooses memory select 1
);

  typedef struct packed {
    logic [15:0][7:0] regs;     // visible register copies
    logic [7:0]       cnt_sec;  // internal counters
    logic [7:0]       cnt_min;
    logic [7:0]       cnt_hour;
    logic [7:0]       cnt_wday;
    logic [7:0]       cnt_date;
    logic [7:0]       cnt_mon;
    logic [7:0]       cnt_year;
    logic [7:0]       cnt_cent;
    logic [31:0]      tick;     // divider to one-second enable
    logic             update;   // transfer in progress (one cycle)
    logic             wr_prev;  // write window of last cycle
    logic             rd_prev;  // read of flags in last cycle
    logic             fail;     // power failure seen
    logic             recover;  // recovery period running
    logic [31:0]      rec_cnt;
    logic [7:0]       dout;
    logic             doe;
    logic             sel0;
    logic             sel1;
    logic             msel_oe;
    logic             rst_act;
    logic             rst_oe;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // bcd helpers

  // increments a packed bcd byte, wrapping to lo above hi
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] r;
    r = 8'h00;
    if (v >= hi) begin
      r = lo;
    end else if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // last day of a month, bcd, leap years on year divisible by four
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic [7:0] r;
    r = 8'h31;
    case (mon)
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      8'h02: r = ((yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00))) ? 8'h29 : 8'h28;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic       wr_win;
  logic       rd_win;
  logic       guard;
  logic       tick_en;
  logic [7:0] ctrl;
  logic [7:0] rd_mux;

  always_comb begin
    nxt_st  = st_ff;
    guard   = deselect_threshold | st_ff.fail;
    wr_win  = !reg_sel_n && !wr_strobe_n && !guard;
    rd_win  = !reg_sel_n && wr_strobe_n && !rd_enable_n && !guard;
    ctrl    = st_ff.regs[rtc_guard_pkg::OFS_CONTROL];
    tick_en = 1'b0;
    rd_mux  = st_ff.regs[reg_addr];
    nxt_st.update = 1'b0;

    // one-second divider; stopped by the oscillator halt bit or the set-time bit
    if (st_ff.regs[rtc_guard_pkg::OFS_SECONDS][rtc_guard_pkg::BIT_OSC_HALT] || ctrl[rtc_guard_pkg::BIT_SET_TIME]) begin
      nxt_st.tick = 32'h0;
    end else if (st_ff.tick >= 32'(SECOND_COUNT - 1)) begin
      nxt_st.tick = 32'h0;
      tick_en     = 1'b1;
    end else begin
      nxt_st.tick = st_ff.tick + 32'h1;
    end

    // counters advance in bcd, carrying up through the calendar
    if (tick_en) begin
      nxt_st.cnt_sec = bcd_inc(st_ff.cnt_sec, 8'h00, 8'h59);
      if (st_ff.cnt_sec == 8'h59) begin
        nxt_st.cnt_min = bcd_inc(st_ff.cnt_min, 8'h00, 8'h59);
        if (st_ff.cnt_min == 8'h59) begin
          nxt_st.cnt_hour = bcd_inc(st_ff.cnt_hour, 8'h00, 8'h23);
          if (st_ff.cnt_hour == 8'h23) begin
            nxt_st.cnt_wday = bcd_inc(st_ff.cnt_wday, 8'h01, 8'h07);
            nxt_st.cnt_date = bcd_inc(st_ff.cnt_date, 8'h01, month_end(st_ff.cnt_mon, st_ff.cnt_year));
            if (st_ff.cnt_date == month_end(st_ff.cnt_mon, st_ff.cnt_year)) begin
              nxt_st.cnt_mon = bcd_inc(st_ff.cnt_mon, 8'h01, 8'h12);
              if (st_ff.cnt_mon == 8'h12) begin
                nxt_st.cnt_year = bcd_inc(st_ff.cnt_year, 8'h00, 8'h99);
                if (st_ff.cnt_year == 8'h99) begin
                  nxt_st.cnt_cent = bcd_inc(st_ff.cnt_cent, 8'h00, 8'h99);
                end
              end
            end
          end
        end
      end
      // transfer starts only while neither halt bit is set; once started it finishes
      nxt_st.update = !ctrl[rtc_guard_pkg::BIT_FREEZE] && !ctrl[rtc_guard_pkg::BIT_SET_TIME];
    end

    // simultaneous copy of all counters; freeze written mid-transfer waits for it
    if (st_ff.update) begin
      nxt_st.regs[rtc_guard_pkg::OFS_SECONDS][6:0]     = st_ff.cnt_sec[6:0];
      nxt_st.regs[rtc_guard_pkg::OFS_MINUTES]          = st_ff.cnt_min;
      nxt_st.regs[rtc_guard_pkg::OFS_HOURS]            = st_ff.cnt_hour;
      nxt_st.regs[rtc_guard_pkg::OFS_WEEKDAY][2:0]     = st_ff.cnt_wday[2:0];
      nxt_st.regs[rtc_guard_pkg::OFS_DAY_OF_MONTH]     = st_ff.cnt_date;
      nxt_st.regs[rtc_guard_pkg::OFS_MONTH]            = st_ff.cnt_mon;
      nxt_st.regs[rtc_guard_pkg::OFS_YEAR]             = st_ff.cnt_year;
      nxt_st.regs[rtc_guard_pkg::OFS_CENTURY]          = st_ff.cnt_cent;
    end

    // hardware flags; the set wins over a clear by reading
    if (st_ff.rd_prev && !rd_win) begin
      nxt_st.regs[rtc_guard_pkg::OFS_STATUS_FLAGS][rtc_guard_pkg::BIT_WD_EXPIRED]  = 1'b0;
      nxt_st.regs[rtc_guard_pkg::OFS_STATUS_FLAGS][rtc_guard_pkg::BIT_ALARM_MATCH] = 1'b0;
    end
    if (wd_expired_in) begin
      nxt_st.regs[rtc_guard_pkg::OFS_STATUS_FLAGS][rtc_guard_pkg::BIT_WD_EXPIRED] = 1'b1;
    end
    if (alarm_match_in) begin
      nxt_st.regs[rtc_guard_pkg::OFS_STATUS_FLAGS][rtc_guard_pkg::BIT_ALARM_MATCH] = 1'b1;
    end
    nxt_st.regs[rtc_guard_pkg::OFS_STATUS_FLAGS][rtc_guard_pkg::BIT_BATT_LOW] = batt_low_in;
    nxt_st.rd_prev = rd_win && (reg_addr == rtc_guard_pkg::OFS_STATUS_FLAGS);

    // write in every cycle of the strobe window, any register but flags stores the bus byte
    nxt_st.wr_prev = wr_win;
    if (wr_win) begin
      if (reg_addr != rtc_guard_pkg::OFS_STATUS_FLAGS) begin
        nxt_st.regs[reg_addr] = data_in;
      end
    end

    // leaving set-time loads counters and restarts the second
    if (ctrl[rtc_guard_pkg::BIT_SET_TIME] && wr_win && reg_addr == rtc_guard_pkg::OFS_CONTROL
        && !data_in[rtc_guard_pkg::BIT_SET_TIME]) begin
      nxt_st.cnt_sec  = {1'b0, st_ff.regs[rtc_guard_pkg::OFS_SECONDS][6:0]};
      nxt_st.cnt_min  = st_ff.regs[rtc_guard_pkg::OFS_MINUTES];
      nxt_st.cnt_hour = st_ff.regs[rtc_guard_pkg::OFS_HOURS];
      nxt_st.cnt_wday = {5'h00, st_ff.regs[rtc_guard_pkg::OFS_WEEKDAY][2:0]};
      nxt_st.cnt_date = st_ff.regs[rtc_guard_pkg::OFS_DAY_OF_MONTH];
      nxt_st.cnt_mon  = st_ff.regs[rtc_guard_pkg::OFS_MONTH];
      nxt_st.cnt_year = st_ff.regs[rtc_guard_pkg::OFS_YEAR];
      nxt_st.cnt_cent = st_ff.regs[rtc_guard_pkg::OFS_CENTURY];
      nxt_st.tick     = 32'h0;
    end
    // leaving freeze restarts the second so the next update is a full second away
    if (ctrl[rtc_guard_pkg::BIT_FREEZE] && wr_win && reg_addr == rtc_guard_pkg::OFS_CONTROL
        && !data_in[rtc_guard_pkg::BIT_FREEZE]) begin
      nxt_st.tick = 32'h0;
    end

    // power-fail sequencing
    if (deselect_threshold) begin
      nxt_st.fail    = 1'b1;
      nxt_st.recover = 1'b0;
      nxt_st.rec_cnt = 32'h0;
      nxt_st.update  = 1'b0;
    end else if (st_ff.fail) begin
      nxt_st.fail    = 1'b0;
      nxt_st.recover = 1'b1;
      nxt_st.rec_cnt = 32'h0;
      // power-down time stays visible after the return
      nxt_st.regs[rtc_guard_pkg::OFS_CONTROL][rtc_guard_pkg::BIT_FREEZE]   = 1'b1;
      nxt_st.regs[rtc_guard_pkg::OFS_CONTROL][rtc_guard_pkg::BIT_SET_TIME] = 1'b0;
    end else if (st_ff.recover) begin
      if (st_ff.rec_cnt >= 32'(RECOVERY_COUNT - 1)) begin
        nxt_st.recover = 1'b0;
      end
      nxt_st.rec_cnt = st_ff.rec_cnt + 32'h1;
    end

    // pin drivers; the recovery period counts as a guarded state too
    nxt_st.rst_act = deselect_threshold | st_ff.fail | nxt_st.recover;
    nxt_st.rst_oe  = nxt_st.rst_act && !switchover_threshold;
    nxt_st.sel0    = (guard | nxt_st.recover) ? 1'b1 : (mem_sel_in_n | bank_sel);
    nxt_st.sel1    = (guard | nxt_st.recover) ? 1'b1 : (mem_sel_in_n | !bank_sel);
    nxt_st.msel_oe = !switchover_threshold;
    nxt_st.dout    = rd_mux;
    nxt_st.doe     = rd_win && !switchover_threshold;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; counters live on, only outputs release at switchover

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.regs[rtc_guard_pkg::OFS_CONTROL]      <= rtc_guard_pkg::RST_CONTROL;
      st_ff.regs[rtc_guard_pkg::OFS_DAY_OF_MONTH] <= rtc_guard_pkg::RST_DAY_MONTH;
      st_ff.regs[rtc_guard_pkg::OFS_MONTH]        <= rtc_guard_pkg::RST_DAY_MONTH;
      st_ff.regs[rtc_guard_pkg::OFS_WEEKDAY]      <= rtc_guard_pkg::RST_DAY_MONTH;
      st_ff.cnt_date <= rtc_guard_pkg::RST_DAY_MONTH;
      st_ff.cnt_mon  <= rtc_guard_pkg::RST_DAY_MONTH;
      st_ff.cnt_wday <= rtc_guard_pkg::RST_DAY_MONTH;
      st_ff.sel0     <= 1'b1;
      st_ff.sel1     <= 1'b1;
      st_ff.rst_act  <= 1'b1;
      st_ff.recover  <= 1'b1;  // power-on runs the recovery period
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign data_out       = st_ff.dout;
  assign data_oe        = st_ff.doe;
  assign mem_sel0_out_n = st_ff.sel0;
  assign mem_sel1_out_n = st_ff.sel1;
  assign mem_sel_oe     = st_ff.msel_oe;
  assign sys_rst_out    = 1'b0 | st_ff.rst_act;
  assign sys_rst_oe     = st_ff.rst_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_fail_seen;
    deselect_threshold;
  endsequence

  sequence s_write_ctrl_clear_set;
    st_ff.regs[rtc_guard_pkg::OFS_CONTROL][rtc_guard_pkg::BIT_SET_TIME] && wr_win
      && reg_addr == rtc_guard_pkg::OFS_CONTROL && !data_in[rtc_guard_pkg::BIT_SET_TIME];
  endsequence

  a_no_write_guard: assert property (@(posedge clk_sys) disable iff (rst)
    deselect_threshold && !reg_sel_n && !wr_strobe_n && reg_addr == rtc_guard_pkg::OFS_MINUTES
      |=> st_ff.regs[rtc_guard_pkg::OFS_MINUTES] == $past(st_ff.regs[rtc_guard_pkg::OFS_MINUTES]))
    else $error("register written during deselect");

  a_reset_on_fail: assert property (@(posedge clk_sys) disable iff (rst)
    s_fail_seen |=> sys_rst_out ##1 sys_rst_out)
    else $error("reset not held after deselect");

  a_sel_forced_high: assert property (@(posedge clk_sys) disable iff (rst)
    s_fail_seen |=> mem_sel0_out_n && mem_sel1_out_n)
    else $error("memory select not inhibited");

  a_hiz_switchover: assert property (@(posedge clk_sys) disable iff (rst)
    switchover_threshold |=> !data_oe && !mem_sel_oe && !sys_rst_oe)
    else $error("output driven below switchover");

  a_recover_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(st_ff.fail) |-> st_ff.recover && mem_sel0_out_n ##1 mem_sel1_out_n)
    else $error("memory select released early");

  a_reset_recover: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.recover |-> sys_rst_out)
    else $error("reset released during recovery");

  a_freeze_holds: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.regs[rtc_guard_pkg::OFS_CONTROL][rtc_guard_pkg::BIT_FREEZE] && !st_ff.update && !wr_win
      |=> st_ff.regs[rtc_guard_pkg::OFS_MINUTES] == $past(st_ff.regs[rtc_guard_pkg::OFS_MINUTES]))
    else $error("visible time changed while frozen");

  a_settime_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_write_ctrl_clear_set |=> st_ff.cnt_min == $past(st_ff.regs[rtc_guard_pkg::OFS_MINUTES]) && st_ff.tick == 32'h0)
    else $error("counters not loaded on set-time clear");

  a_powerup_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(st_ff.fail) |-> st_ff.regs[rtc_guard_pkg::OFS_CONTROL][rtc_guard_pkg::BIT_FREEZE]
      && !st_ff.regs[rtc_guard_pkg::OFS_CONTROL][rtc_guard_pkg::BIT_SET_TIME])
    else $error("freeze not set after power return");

endmodule

/* File: verification/host_pin_model.sv */
// far-side pin model: data bus, memory selects and open-drain reset pin
module host_pin_model (
  input  wire logic       clk_sys,        // system clock
  input  wire logic [7:0] data_out,       // device read data
  input  wire logic       data_oe,        // device drives data bus
  input  wire logic       mem_sel0_out_n, // memory select 0
  input  wire logic       mem_sel1_out_n, // memory select 1
  input  wire logic       mem_sel_oe,     // memory select drive enable
  input  wire logic       sys_rst_out,    // reset pull-down request
  input  wire logic       sys_rst_oe,     // reset open-drain enable
  output logic [7:0]      bus_q,          // level seen by the host
  output logic            sel0_pin_n,     // select 0 pin level
  output logic            sel1_pin_n,     // select 1 pin level
  output logic            rst_pin_n       // reset pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_ff;
  // a released bus shows the inverse of its last value, so stale data never passes
  always_ff @(posedge clk_sys) begin
    if (data_oe) begin
      last_ff <= data_out;
    end
  end
  assign bus_q      = data_oe ? data_out : ~last_ff;
  // undriven selects sit at the battery rail through the sram pull-ups
  assign sel0_pin_n = mem_sel_oe ? mem_sel0_out_n : 1'b1;
  assign sel1_pin_n = mem_sel_oe ? mem_sel1_out_n : 1'b1;
  // open drain with external pull-up
  assign rst_pin_n  = (sys_rst_oe && sys_rst_out) ? 1'b0 : 1'b1;
endmodule

/* File: verification/rtc_register_file_power_guard_tb.sv */
// testbench for the timekeeping register file and power guard
module rtc_register_file_power_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint RC = 20; // shortened recovery period
  localparam longint SC = 10; // shortened second
  logic clk_sys, rst, reg_sel_n, wr_strobe_n, rd_enable_n, mem_sel_in_n, bank_sel;
  logic deselect_threshold, switchover_threshold, wd_expired_in, alarm_match_in, batt_low_in;
  logic [3:0] reg_addr;
  logic [7:0] data_in, data_out, bus_q, d, s0;
  logic data_oe, mem_sel0_out_n, mem_sel1_out_n, mem_sel_oe, sys_rst_out, sys_rst_oe;
  logic sel0_pin_n, sel1_pin_n, rst_pin_n;
  int miscompares, samples_checked, n;
  logic [7:0] rv [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h40, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  rtc_register_file_power_guard #(.RECOVERY_COUNT(RC), .SECOND_COUNT(SC)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_sel_n(reg_sel_n), .wr_strobe_n(wr_strobe_n),
    .rd_enable_n(rd_enable_n), .reg_addr(reg_addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .mem_sel_in_n(mem_sel_in_n), .mem_sel0_out_n(mem_sel0_out_n),
    .mem_sel1_out_n(mem_sel1_out_n), .mem_sel_oe(mem_sel_oe), .sys_rst_out(sys_rst_out),
    .sys_rst_oe(sys_rst_oe), .deselect_threshold(deselect_threshold),
    .switchover_threshold(switchover_threshold), .wd_expired_in(wd_expired_in),
    .alarm_match_in(alarm_match_in), .batt_low_in(batt_low_in), .bank_sel(bank_sel));
  host_pin_model pins (
    .clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .mem_sel0_out_n(mem_sel0_out_n),
    .mem_sel1_out_n(mem_sel1_out_n), .mem_sel_oe(mem_sel_oe), .sys_rst_out(sys_rst_out),
    .sys_rst_oe(sys_rst_oe), .bus_q(bus_q), .sel0_pin_n(sel0_pin_n), .sel1_pin_n(sel1_pin_n),
    .rst_pin_n(rst_pin_n));
  ////////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // write held one full cycle with select and strobe low, address stable
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_sel_n <= 1'b0; wr_strobe_n <= 1'b0; reg_addr <= a; data_in <= v;
    @(posedge clk_sys);
    reg_sel_n <= 1'b1; wr_strobe_n <= 1'b1;
  endtask
  // read held until the registered answer has settled
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_sel_n <= 1'b0; wr_strobe_n <= 1'b1; rd_enable_n <= 1'b0; reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 v = bus_q;
    @(posedge clk_sys);
    reg_sel_n <= 1'b1; rd_enable_n <= 1'b1;
  endtask
  // bounded wait for the reset output to let go
  task automatic wait_release(output int cnt);
    cnt = 0;
    while (sys_rst_out !== 1'b0 && cnt < 200) begin
      @(posedge clk_sys);
      cnt++;
    end
    if (cnt >= 200) begin
      miscompares++;
      finish_test();
    end
  endtask
  // hang guard
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; reg_sel_n = 1'b1; wr_strobe_n = 1'b1; rd_enable_n = 1'b1; reg_addr = 4'h0;
    data_in = 8'h00; mem_sel_in_n = 1'b1; bank_sel = 1'b0; deselect_threshold = 1'b0;
    switchover_threshold = 1'b0; wd_expired_in = 1'b0; alarm_match_in = 1'b0; batt_low_in = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    mem_sel_in_n <= 1'b0;
    @(posedge clk_sys);
    #1 check("rst_pin", rst_pin_n, 8'h00);
    check("sel0_recovery", sel0_pin_n, 8'h01);
    wait_release(n);
    check("recovery_long", n > 8, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 check("sel0_free", sel0_pin_n, 8'h00);
    bank_sel <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check("sel1_bank", {sel1_pin_n, sel0_pin_n}, 8'h01);
    mem_sel_in_n <= 1'b1;
    // reset contents of all sixteen places
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], d);
      check("reset_value", d, rv[i]);
    end
    wr(rtc_guard_pkg::OFS_STATUS_FLAGS, 8'hff);
    rd(rtc_guard_pkg::OFS_STATUS_FLAGS, d);
    check("flags_ro", d, 8'h00);
    // alarm and timeout fields keep what was written
    for (int i = 2; i < 8; i++) wr(i[3:0], {4'h8, i[3:0]});
    for (int i = 2; i < 8; i++) begin
      rd(i[3:0], d);
      check("alarm_wd_rw", d, {4'h8, i[3:0]});
    end
    // flag events set bits; a read clears the sticky ones
    @(posedge clk_sys);
    wd_expired_in <= 1'b1; alarm_match_in <= 1'b1; batt_low_in <= 1'b1;
    @(posedge clk_sys);
    wd_expired_in <= 1'b0; alarm_match_in <= 1'b0;
    rd(rtc_guard_pkg::OFS_STATUS_FLAGS, d);
    check("flags_set", d, 8'hd0);
    rd(rtc_guard_pkg::OFS_STATUS_FLAGS, d);
    check("flags_clear", d, 8'h10);
    batt_low_in <= 1'b0;
    // set time, then release and watch the bcd carry
    wr(rtc_guard_pkg::OFS_CONTROL, 8'h80);
    wr(rtc_guard_pkg::OFS_SECONDS, 8'h59);
    wr(rtc_guard_pkg::OFS_MINUTES, 8'h59);
    wr(rtc_guard_pkg::OFS_HOURS, 8'h12);
    repeat (25) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("set_hold", d, 8'h59);
    wr(rtc_guard_pkg::OFS_CONTROL, 8'h00);
    repeat (4) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("set_delay", d, 8'h59);
    repeat (6) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("sec_carry", d, 8'h00);
    rd(rtc_guard_pkg::OFS_MINUTES, d);
    check("min_carry", d, 8'h00);
    rd(rtc_guard_pkg::OFS_HOURS, d);
    check("hour_carry", d, 8'h13);
    // freeze keeps the snapshot; release updates one second later
    wr(rtc_guard_pkg::OFS_CONTROL, 8'h40);
    rd(rtc_guard_pkg::OFS_SECONDS, s0);
    repeat (25) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("freeze_hold", d, s0);
    wr(rtc_guard_pkg::OFS_CONTROL, 8'h00);
    repeat (4) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("freeze_delay", d, s0);
    repeat (6) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("freeze_resume", d !== s0, 8'h01);
    // oscillator halt written without set-time
    wr(rtc_guard_pkg::OFS_SECONDS, 8'h80);
    repeat (3) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, s0);
    check("halt_bit", s0[7], 8'h01);
    repeat (25) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("halt_stop", d, s0);
    wr(rtc_guard_pkg::OFS_SECONDS, 8'h00);
    repeat (14) @(posedge clk_sys);
    rd(rtc_guard_pkg::OFS_SECONDS, d);
    check("halt_resume", d !== s0, 8'h01);
    // supply failure, battery switchover and return
    deselect_threshold <= 1'b1;
    mem_sel_in_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check("fail_rst", rst_pin_n, 8'h00);
    check("fail_sel", sel1_pin_n, 8'h01);
    wr(rtc_guard_pkg::OFS_MINUTES, 8'h33);
    switchover_threshold <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check("hiz", {data_oe, mem_sel_oe, sys_rst_oe}, 8'h00);
    switchover_threshold <= 1'b0;
    deselect_threshold <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check("up_rst", rst_pin_n, 8'h00);
    check("up_sel", sel1_pin_n, 8'h01);
    wait_release(n);
    check("up_recovery", n > 8, 8'h01);
    mem_sel_in_n <= 1'b1;
    rd(rtc_guard_pkg::OFS_CONTROL, d);
    check("up_control", d, 8'h40);
    rd(rtc_guard_pkg::OFS_MINUTES, d);
    check("fail_write", d !== 8'h33, 8'h01);
    finish_test();
  end
endmodule
